// ===== common/gcrf_consts.svh
// Purpose: Offsets, field positions, reset values and scale shifts of the gauge configuration registers
// Assumes: 16-bit registers at word offsets; cell voltage counts of 78.125 uV
// Notes:   Included by the package and the register file; guarded against double inclusion
`ifndef GCRF_CONSTS_SVH
`define GCRF_CONSTS_SVH

// ************************************************************
// Register map
// ************************************************************
`define GCRF_ADDR_W       8
`define GCRF_CAP_OFFSET   8'h18
`define GCRF_THR_OFFSET   8'h3A
`define GCRF_CAP_RESET    16'h0BB8
`define GCRF_THR_RESET    16'hA561

// ************************************************************
// Threshold fields and scaling
// ************************************************************
`define GCRF_VE_MSB       15
`define GCRF_VE_LSB       7
`define GCRF_VR_MSB       6
`define GCRF_VR_LSB       0
// 10 mV step over 78.125 uV count is 128, 40 mV step is 512
`define GCRF_VE_SHIFT     7
`define GCRF_VR_SHIFT     9

`endif

// ===== common/gcrf_pkg.sv
// Purpose: Types and shared conversions of the gauge configuration register block
// Assumes: gcrf_consts.svh on the include path
// Notes:   Value formats are plain 16-bit words, signed where two's complement; the threshold field types are 9 and 7 bits
package gcrf_pkg;
`include "gcrf_consts.svh"

    // ************************************************************
    // Value formats
    // ************************************************************
    typedef logic        [15:0] gcrf_word_type;
    typedef logic        [15:0] gcrf_capacity_type; // 5.0 uVh per count
    typedef logic        [15:0] gcrf_percent_type;  // 1/256 % per count
    typedef logic        [15:0] gcrf_voltage_type;  // 78.125 uV per count
    typedef logic signed [15:0] gcrf_current_type;  // 1.5625 uV per count
    typedef logic signed [15:0] gcrf_temp_type;     // 1/256 degC per count
    typedef logic        [8:0]  gcrf_ve_type;       // 10 mV per count
    typedef logic        [6:0]  gcrf_vr_type;       // 40 mV per count

    // ************************************************************
    // Empty detection states
    // ************************************************************
    typedef enum logic [1:0] {
        GCRF_ARMED = 2'b01,
        GCRF_EMPTY = 2'b10
    } gcrf_empty_state_type;

    // Empty target as cell voltage counts
    function automatic gcrf_voltage_type gcrf_ve_counts(input gcrf_ve_type ve);
        return 16'(ve) << `GCRF_VE_SHIFT;
    endfunction

    // Recovery level as cell voltage counts
    function automatic gcrf_voltage_type gcrf_vr_counts(input gcrf_vr_type vr);
        return 16'(vr) << `GCRF_VR_SHIFT;
    endfunction
endpackage

// ===== verilog/gcrf_empty_detect.sv
// Purpose: Empty detection with recovery hysteresis
// Assumes: sample_i marks a new cell voltage
// Notes:   Output is a registered level
`timescale 1ns/1ps
`default_nettype none
module gcrf_empty_detect (
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      sample_i,
    input  wire gcrf_pkg::gcrf_voltage_type cell_voltage_i,
    input  wire gcrf_pkg::gcrf_ve_type     empty_target_i,
    input  wire gcrf_pkg::gcrf_vr_type     recovery_i,
    output logic                           empty_o
);
    import gcrf_pkg::*;

    typedef struct packed {
        gcrf_empty_state_type state;
        logic                 empty;
    } gcrf_det_state_type;

    gcrf_det_state_type r;
    gcrf_det_state_type next_r;

    // ************************************************************
    // Hysteresis machine
    // ************************************************************
    // Stays empty until voltage is above recovery, so load dips do not chatter
    always_comb begin
        next_r = r;
        if (sample_i) begin
            unique case (r.state)
                GCRF_ARMED: begin
                    if (cell_voltage_i <= gcrf_ve_counts(empty_target_i)) begin
                        next_r.state = GCRF_EMPTY;
                    end
                end
                GCRF_EMPTY: begin
                    if (cell_voltage_i > gcrf_vr_counts(recovery_i)) begin
                        next_r.state = GCRF_ARMED;
                    end
                end
                default: begin
                    next_r.state = GCRF_ARMED;
                end
            endcase
        end
        next_r.empty = (next_r.state == GCRF_EMPTY);
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            r <= '{state: GCRF_ARMED, empty: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign empty_o = r.empty;
endmodule // gcrf_empty_detect
`default_nettype wire

// ===== verilog/gcrf_value_report.sv
// Purpose: Registered reporting of gauge values in their standard formats
// Assumes: Raw current and capacity arrive already scaled as sense resistor voltages
// Notes:   Updated only on sample_i
`timescale 1ns/1ps
`default_nettype none
module gcrf_value_report (
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       sample_i,
    input  wire logic                       empty_i,
    input  wire gcrf_pkg::gcrf_voltage_type  cell_voltage_i,
    input  wire gcrf_pkg::gcrf_ve_type      empty_target_i,
    input  wire gcrf_pkg::gcrf_percent_type  raw_soc_i,
    input  wire gcrf_pkg::gcrf_capacity_type raw_capacity_i,
    input  wire gcrf_pkg::gcrf_current_type  raw_current_i,
    input  wire gcrf_pkg::gcrf_temp_type     raw_temp_i,
    output gcrf_pkg::gcrf_percent_type       soc_o,
    output gcrf_pkg::gcrf_capacity_type      capacity_o,
    output gcrf_pkg::gcrf_current_type       current_o,
    output gcrf_pkg::gcrf_temp_type          temp_o
);
    import gcrf_pkg::*;

    typedef struct packed {
        gcrf_percent_type  soc;
        gcrf_capacity_type cap;
        gcrf_current_type  cur;
        gcrf_temp_type     temp;
    } gcrf_rep_state_type;

    gcrf_rep_state_type r;
    gcrf_rep_state_type next_r;
    logic               at_empty;

    // ************************************************************
    // Reporting relative to the empty target
    // ************************************************************
    // Charge and capacity pin to zero at or below target, whatever the raw estimate says
    always_comb begin
        next_r   = r;
        at_empty = empty_i || (cell_voltage_i <= gcrf_ve_counts(empty_target_i));
        if (sample_i) begin
            next_r.soc  = at_empty ? 16'h0000 : raw_soc_i;
            next_r.cap  = at_empty ? 16'h0000 : raw_capacity_i;
            next_r.cur  = raw_current_i;
            next_r.temp = raw_temp_i;
        end
    end

    // Value registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign soc_o      = r.soc;
    assign capacity_o = r.cap;
    assign current_o  = r.cur;
    assign temp_o     = r.temp;
endmodule // gcrf_value_report
`default_nettype wire

// ===== verilog/gcrf_regs.sv
// Purpose: Gauge configuration registers, empty detection and value reporting
// Assumes: Word register port decoded from the serial link outside this block
// Notes:   Read data comes one cycle after the read strobe
//
// Contract
// - Registers without a layout of their own use the common format of their type.
// - Current and capacity values are sense resistor voltages, left to the host to divide.
// - Capacity values are unsigned 16-bit at 5.0 uVh per count up to 327.675 mVh.
// - Percentage values are 1/256 percent per count so the upper byte reads whole percent.
// - Current values are signed two's complement at 1.5625 uV per count.
// - Temperature values are signed two's complement at 1/256 degC per count.
// - The nominal cell capacity register uses capacity format and resets to 0x0BB8.
// - The threshold register resets to 0xA561, a 3.3 V target and 3.88 V recovery.
// - The empty target field counts 10 mV steps from 0 V to 5.11 V, 3.3 V after reset.
// - Charge and capacity are reported relative to the target, reaching 0% at it.
// - The recovery field counts 40 mV steps from 0 V to 5.08 V, 3.88 V after reset.
// - Empty detection clears and re-arms only once voltage rises above recovery.
`timescale 1ns/1ps
`default_nettype none
`include "gcrf_consts.svh"
module gcrf_regs (
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    // Register port
    input  wire logic [7:0]                 reg_addr_i,
    input  wire logic                       reg_wr_i,
    input  wire gcrf_pkg::gcrf_word_type     reg_wdata_i,
    input  wire logic                       reg_rd_i,
    output gcrf_pkg::gcrf_word_type          reg_rdata_o,
    output logic                            reg_rvalid_o,
    // Measurement side
    input  wire logic                       sample_i,
    input  wire gcrf_pkg::gcrf_voltage_type  cell_voltage_i,
    input  wire gcrf_pkg::gcrf_percent_type  raw_soc_i,
    input  wire gcrf_pkg::gcrf_capacity_type raw_capacity_i,
    input  wire gcrf_pkg::gcrf_current_type  raw_current_i,
    input  wire gcrf_pkg::gcrf_temp_type     raw_temp_i,
    // Configuration and results
    output gcrf_pkg::gcrf_capacity_type      nominal_cell_capacity_o,
    output gcrf_pkg::gcrf_ve_type            empty_target_voltage_o,
    output gcrf_pkg::gcrf_vr_type            recovery_voltage_o,
    output logic                            empty_o,
    output gcrf_pkg::gcrf_percent_type       soc_o,
    output gcrf_pkg::gcrf_capacity_type      capacity_o,
    output gcrf_pkg::gcrf_current_type       current_o,
    output gcrf_pkg::gcrf_temp_type          temp_o
);
    import gcrf_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        gcrf_capacity_type nominal_cell_capacity;
        gcrf_word_type     empty_recovery_thresholds;
        gcrf_word_type     rdata;
        logic              rvalid;
    } gcrf_reg_state_type;

    gcrf_reg_state_type r;
    gcrf_reg_state_type next_r;
    logic               hit_cap;
    logic               hit_thr;

    // ************************************************************
    // Register file
    // ************************************************************
    // Read of a word written in the same cycle returns the old value; the host never overlaps them
    always_comb begin
        next_r  = r;
        hit_cap = (reg_addr_i == `GCRF_CAP_OFFSET);
        hit_thr = (reg_addr_i == `GCRF_THR_OFFSET);
        next_r.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            if (hit_cap) begin
                next_r.rdata = r.nominal_cell_capacity;
            end else if (hit_thr) begin
                next_r.rdata = r.empty_recovery_thresholds;
            end else begin
                next_r.rdata = 16'h0000; // Unmapped reads as zero
            end
        end
        if (reg_wr_i && hit_cap) begin
            next_r.nominal_cell_capacity = reg_wdata_i;
        end
        if (reg_wr_i && hit_thr) begin
            next_r.empty_recovery_thresholds = reg_wdata_i;
        end
    end

    // Reset values give a working gauge before the host configures anything
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            r <= '{nominal_cell_capacity:     `GCRF_CAP_RESET,
                   empty_recovery_thresholds: `GCRF_THR_RESET,
                   rdata:                     16'h0000,
                   rvalid:                    1'b0};
        end else begin
            r <= next_r;
        end
    end

    // Field extraction straight off the register flops
    assign reg_rdata_o             = r.rdata;
    assign reg_rvalid_o            = r.rvalid;
    assign nominal_cell_capacity_o = r.nominal_cell_capacity;
    assign empty_target_voltage_o  = r.empty_recovery_thresholds[`GCRF_VE_MSB:`GCRF_VE_LSB];
    assign recovery_voltage_o      = r.empty_recovery_thresholds[`GCRF_VR_MSB:`GCRF_VR_LSB];

    // ************************************************************
    // Empty detection and reporting
    // ************************************************************
    logic empty_flag;

    gcrf_empty_detect u_empty_detect (
        .clock_i        (clock_i),
        .rst_n_i        (rst_n_i),
        .sample_i       (sample_i),
        .cell_voltage_i (cell_voltage_i),
        .empty_target_i (empty_target_voltage_o),
        .recovery_i     (recovery_voltage_o),
        .empty_o        (empty_flag)
    );

    gcrf_value_report u_value_report (
        .clock_i        (clock_i),
        .rst_n_i        (rst_n_i),
        .sample_i       (sample_i),
        .empty_i        (empty_flag),
        .cell_voltage_i (cell_voltage_i),
        .empty_target_i (empty_target_voltage_o),
        .raw_soc_i      (raw_soc_i),
        .raw_capacity_i (raw_capacity_i),
        .raw_current_i  (raw_current_i),
        .raw_temp_i     (raw_temp_i),
        .soc_o          (soc_o),
        .capacity_o     (capacity_o),
        .current_o      (current_o),
        .temp_o         (temp_o)
    );

    assign empty_o = empty_flag;

    // ************************************************************
    // Assertions
    // ************************************************************
    // Helper terms; the checks watch only the ports of this block, inputs as well as outputs
    logic             rst_seen;
    gcrf_voltage_type ve_cnt;
    gcrf_voltage_type vr_cnt;

    assign ve_cnt = gcrf_ve_counts(empty_target_voltage_o);
    assign vr_cnt = gcrf_vr_counts(recovery_voltage_o);

    // Marks that a reset has been seen, so the first cycles are not judged
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rst_seen <= 1'b1;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_cap_reset_value: assert property (rst_seen && $past(!rst_n_i) |->
        nominal_cell_capacity_o == `GCRF_CAP_RESET)
        else $error("capacity register not at reset value");

    a_thr_reset_value: assert property (rst_seen && $past(!rst_n_i) |->
        {empty_target_voltage_o, recovery_voltage_o} == `GCRF_THR_RESET)
        else $error("threshold fields not at reset value");

    a_thr_write_fields: assert property (reg_wr_i && reg_addr_i == `GCRF_THR_OFFSET |=>
        empty_target_voltage_o == $past(reg_wdata_i[15:7]) && recovery_voltage_o == $past(reg_wdata_i[6:0]))
        else $error("threshold write did not land in its fields");

    a_cap_write_hold: assert property (reg_wr_i && reg_addr_i == `GCRF_CAP_OFFSET |=>
        nominal_cell_capacity_o == $past(reg_wdata_i) ##1
        (nominal_cell_capacity_o == $past(nominal_cell_capacity_o) || $past(reg_wr_i)))
        else $error("capacity register write lost or changed");

    a_read_back_data: assert property (reg_rd_i && reg_addr_i == `GCRF_THR_OFFSET && !reg_wr_i |=>
        reg_rvalid_o && reg_rdata_o == {empty_target_voltage_o, recovery_voltage_o})
        else $error("threshold read returned wrong data");

    a_read_unmapped: assert property (reg_rd_i && reg_addr_i != `GCRF_CAP_OFFSET
        && reg_addr_i != `GCRF_THR_OFFSET |=> reg_rvalid_o && reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");

    // A target set above recovery lets an empty cell re-arm even at the target
    a_soc_zero_empty: assert property (sample_i && cell_voltage_i <= ve_cnt |=>
        soc_o == 16'h0000 && capacity_o == 16'h0000
        && empty_o == !($past(empty_o) && $past(cell_voltage_i) > $past(vr_cnt)))
        else $error("charge not zero at empty target");

    a_rvalid_pulse: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read answer without a read strobe");

    a_soc_pass_full: assert property (sample_i && !empty_o && cell_voltage_i > ve_cnt |=>
        soc_o == $past(raw_soc_i) && capacity_o == $past(raw_capacity_i))
        else $error("charge not passed through above target");

    a_signed_pass: assert property (sample_i |=>
        current_o == $past(raw_current_i) && temp_o == $past(raw_temp_i))
        else $error("current or temperature not reported");

    a_empty_hold: assert property (empty_o && sample_i && cell_voltage_i <= vr_cnt |=>
        empty_o)
        else $error("empty cleared below recovery level");

    a_empty_rearm: assert property (empty_o && sample_i && cell_voltage_i > vr_cnt |=>
        !empty_o)
        else $error("empty not cleared above recovery level");

    a_empty_steady: assert property (!sample_i |=> $stable(empty_o) && $stable(soc_o)
        && $stable(temp_o))
        else $error("report changed without a sample");

    c_cap_written: cover property (reg_wr_i && reg_addr_i == `GCRF_CAP_OFFSET ##1 reg_rd_i
        && reg_addr_i == `GCRF_CAP_OFFSET ##1 reg_rvalid_o);

    c_empty_cycle: cover property ($rose(empty_o) ##[1:50] $fell(empty_o));

    c_thr_changed: cover property (reg_wr_i && reg_addr_i == `GCRF_THR_OFFSET
        && reg_wdata_i != `GCRF_THR_RESET);

    c_hysteresis_band: cover property (empty_o && sample_i && cell_voltage_i > ve_cnt
        && cell_voltage_i <= vr_cnt);
endmodule // gcrf_regs
`default_nettype wire

// ===== tb/gcrf_host_model.sv
// Purpose: Host side of the word register port, issuing single reads and writes
// Assumes: Requests launched 1 ns after a rising edge, one cycle wide
// Notes:   Address is inverted after each request and write data after each write, so stale values never match
`timescale 1ns/1ps
`default_nettype none
module gcrf_host_model (
    input  wire logic                   clock_i,
    input  wire gcrf_pkg::gcrf_word_type reg_rdata_i,
    input  wire logic                   reg_rvalid_i,
    output logic [7:0]                  reg_addr_o,
    output logic                        reg_wr_o,
    output gcrf_pkg::gcrf_word_type      reg_wdata_o,
    output logic                        reg_rd_o
);
    import gcrf_pkg::*;

    // ************************************************************
    // Idle state at time zero
    // ************************************************************
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 16'h0000;
        reg_rd_o    = 1'b0;
    end

    // One write strobe, then the bus goes to the inverse of what it carried
    task automatic write_word(input logic [7:0] addr, input gcrf_word_type data);
        @(posedge clock_i);
        #1;
        reg_addr_o  = addr;
        reg_wdata_o = data;
        reg_wr_o    = 1'b1;
        @(posedge clock_i);
        #1;
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~addr;
        reg_wdata_o = ~data;
    endtask

    // One read strobe; answer sampled in the cycle after the strobe is taken
    task automatic read_word(input logic [7:0] addr, output gcrf_word_type data, output logic valid);
        @(posedge clock_i);
        #1;
        reg_addr_o = addr;
        reg_rd_o   = 1'b1;
        @(posedge clock_i);
        #1;
        reg_rd_o   = 1'b0;
        reg_addr_o = ~addr;
        valid      = reg_rvalid_i;
        data       = reg_rdata_i;
    endtask
endmodule // gcrf_host_model
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench of the gauge configuration registers
// Assumes: Host model drives the register port, bench drives measurements
// Notes:   Empty state is tracked here from the thresholds the bench wrote
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gcrf_pkg::*;

    // ************************************************************
    // Clock, reset and wiring
    // ************************************************************
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [7:0]        addr;
    logic              wr, rd, rvalid, sample = 1'b0, empty;
    gcrf_word_type     wdata, rdata;
    gcrf_voltage_type  volt = 16'h0000;
    gcrf_percent_type  r_soc = 16'h0000, soc;
    gcrf_capacity_type r_cap = 16'h0000, cap, nom_cap;
    gcrf_current_type  r_cur = 16'h0000, cur;
    gcrf_temp_type     r_tmp = 16'h0000, tmp;
    gcrf_ve_type       tgt_o;
    gcrf_vr_type       rec_o;
    int                miscompares = 0;
    int                n_tests = 0;
    int                tgt = 330;
    int                rec = 97;
    logic              exp_empty = 1'b0;
    int                k;
    logic [15:0]       vlist[6] = '{16'hA501, 16'hA500, 16'hB000, 16'hC200, 16'hC201, 16'hA4FF};
    logic [15:0]       thr[2] = '{16'hFFFF, 16'h0000};

    always #50 clk = ~clk;

    gcrf_host_model u_host (
        .clock_i     (clk),
        .reg_rdata_i (rdata),
        .reg_rvalid_i(rvalid),
        .reg_addr_o  (addr),
        .reg_wr_o    (wr),
        .reg_wdata_o (wdata),
        .reg_rd_o    (rd)
    );

    gcrf_regs u_dut (
        .clock_i                (clk),
        .rst_n_i                (rst_n),
        .reg_addr_i             (addr),
        .reg_wr_i               (wr),
        .reg_wdata_i            (wdata),
        .reg_rd_i               (rd),
        .reg_rdata_o            (rdata),
        .reg_rvalid_o           (rvalid),
        .sample_i               (sample),
        .cell_voltage_i         (volt),
        .raw_soc_i              (r_soc),
        .raw_capacity_i         (r_cap),
        .raw_current_i          (r_cur),
        .raw_temp_i             (r_tmp),
        .nominal_cell_capacity_o(nom_cap),
        .empty_target_voltage_o (tgt_o),
        .recovery_voltage_o     (rec_o),
        .empty_o                (empty),
        .soc_o                  (soc),
        .capacity_o             (cap),
        .current_o              (cur),
        .temp_o                 (tmp)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Read through the host and compare the answer pulse and data
    task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
        gcrf_word_type d;
        logic          v;
        u_host.read_word(a, d, v);
        check("rvalid", 16'h0001, {15'h0000, v});
        check("rdata", exp, d);
    endtask

    // Field outputs against the tracked threshold values
    task automatic field_check();
        check("target", 16'(tgt), {7'h00, tgt_o});
        check("recovery", 16'(rec), {9'h000, rec_o});
    endtask

    // Synchronous reset held for three edges; expected state returns to defaults
    task automatic do_reset();
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst_n     = 1'b1;
        tgt       = 330;
        rec       = 97;
        exp_empty = 1'b0;
    endtask

    // One sample; inputs scrambled afterwards since outputs must hold
    task automatic meas(input logic [15:0] v, input logic [15:0] s, input logic [15:0] c,
                        input logic [15:0] i, input logic [15:0] t);
        logic zero;
        zero = exp_empty || (int'(v) <= tgt * 128);
        if (!exp_empty && int'(v) <= tgt * 128)
            exp_empty = 1'b1;
        else if (exp_empty && int'(v) > rec * 512)
            exp_empty = 1'b0;
        @(posedge clk);
        #1;
        {sample, volt, r_soc, r_cap, r_cur, r_tmp} = {1'b1, v, s, c, i, t};
        @(posedge clk);
        #1;
        {sample, volt, r_soc, r_cap, r_cur, r_tmp} = {1'b0, ~v, ~s, ~c, ~i, ~t};
        @(posedge clk);
        #1;
        check("empty", {15'h0000, exp_empty}, {15'h0000, empty});
        check("soc", zero ? 16'h0000 : s, soc);
        check("capacity", zero ? 16'h0000 : c, cap);
        check("current", i, cur);
        check("temp", t, tmp);
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ************************************************************
    // Watchdog against a hang
    // ************************************************************
    initial begin
        #5000000;
        miscompares++;
        $display("ERROR watchdog expected end seen timeout");
        wrap_up();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        do_reset();
        rd_check(8'h18, 16'h0BB8);
        rd_check(8'h3A, 16'hA561);
        field_check();
        check("nominal", 16'h0BB8, nom_cap);
        // Unmapped place answers zero and swallows writes
        u_host.write_word(8'h19, 16'h1234);
        rd_check(8'h19, 16'h0000);
        rd_check(8'h18, 16'h0BB8);
        u_host.write_word(8'h18, 16'hFFFF);
        check("nominal", 16'hFFFF, nom_cap);
        rd_check(8'h18, 16'hFFFF);
        // Format extremes pass through unchanged
        meas(16'hA501, 16'h6480, 16'hFFFF, 16'h8000, 16'h8000);
        meas(16'hFFFF, 16'hFFFF, 16'h0001, 16'h7FFF, 16'h7FFF);
        // Target boundary, hysteresis band, recovery boundary
        for (k = 0; k < 6; k++) begin
            meas(vlist[k], 16'h3200, 16'h0BB8, 16'hFFFF, 16'h1900);
        end
        // Field extremes of the threshold word
        for (k = 0; k < 2; k++) begin
            u_host.write_word(8'h3A, thr[k]);
            tgt = int'(thr[k][15:7]);
            rec = int'(thr[k][6:0]);
            field_check();
            rd_check(8'h3A, thr[k]);
            meas(16'hFF80, 16'h0100, 16'h0002, 16'h0003, 16'h0004);
            meas(16'h0001, 16'h0100, 16'h0002, 16'h0003, 16'h0004);
        end
        // Second reset in mid-run restores defaults
        do_reset();
        rd_check(8'h3A, 16'hA561);
        check("nominal", 16'h0BB8, nom_cap);
        check("empty", 16'h0000, {15'h0000, empty});
        check("soc", 16'h0000, soc);
        meas(16'hA500, 16'h1000, 16'h2000, 16'h0010, 16'h0020);
        wrap_up();
    end
endmodule // tb
`default_nettype wire
